// ### verilog/alarm_pkg.sv
/*
 Package for the alarm response and parameter gate: register offsets,
 field positions, reset values and timing constants.
 Assumes a 10 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
package alarm_pkg;
    localparam int unsigned NUM_ALARMS   = 16;
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned RECOVER_S    = 3600;
    localparam longint unsigned RECOVER_CYCLES = longint'(RECOVER_S) * longint'(CLK_HZ);

    // Register byte offsets
    localparam logic [7:0] OFF_ENABLE   = 8'h00;
    localparam logic [7:0] OFF_WARNCLS  = 8'h04;
    localparam logic [7:0] OFF_MANUAL   = 8'h08;
    localparam logic [7:0] OFF_FUNC     = 8'h0c;
    localparam logic [7:0] OFF_ACTIVE   = 8'h10;
    localparam logic [7:0] OFF_RESET    = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_DEBUG    = 8'h24;

    // Function register fields
    localparam int unsigned F_IGN_UC    = 0;
    localparam int unsigned F_IGN_OC    = 1;
    localparam int unsigned F_MODE_A    = 2;
    localparam int unsigned F_MODE_B    = 3;
    localparam int unsigned F_IGN_PL    = 4;
    localparam int unsigned F_IGN_EF    = 5;
    localparam int unsigned F_IGN_UB    = 6;
    localparam int unsigned F_DEBUG     = 7;
    localparam int unsigned F_AR_LSB    = 8;   // 3-bit auto reset selection

    // Alarm indices: overload, and the alarms with start phase suppression
    localparam int unsigned A_OVERLOAD  = 0;
    localparam int unsigned A_PHASELOSS = 1;
    localparam int unsigned A_EARTH     = 2;
    localparam int unsigned A_UNBAL     = 3;
    localparam int unsigned A_UNDERCUR  = 11;
    localparam int unsigned A_OVERCUR   = 12;

    // Auto reset allowance codes
    localparam logic [2:0] AR_NEVER  = 3'h0;
    localparam logic [2:0] AR_ALWAYS = 3'h4;

    // Reset values
    localparam logic [15:0] RST_ENABLE  = 16'hffff;
    localparam logic [15:0] RST_WARNCLS = 16'h0000;
    localparam logic [15:0] RST_MANUAL  = 16'h0000;
    localparam logic [10:0] RST_FUNC    = 11'h100;

    // Coil range of the single coil reset
    localparam logic [7:0] COIL_FIRST = 8'h41;
    localparam logic [7:0] COIL_LAST  = 8'h6a;

    // Interrupt status bits
    localparam int unsigned I_FAULT   = 0;
    localparam int unsigned I_WARN    = 1;
    localparam int unsigned I_REJECT  = 2;
endpackage

// ### verilog/hour_timer.sv
/*
 Counts the one hour overload free interval; restarts on every overload.
 Assumes aclk at the package rate; the limit is a parameter for simulation.
*/
`timescale 1ns/1ps
module hour_timer #(
    parameter longint unsigned LIMIT = alarm_pkg::RECOVER_CYCLES
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic restart,
    output logic      expired
);
    logic [35:0] cnt_q;
    wire         at_end = (cnt_q >= 36'(LIMIT - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            cnt_q   <= 36'h0;
            expired <= 1'b0;
        end else begin
            cnt_q   <= at_end ? 36'h0 : cnt_q + 36'h1;
            expired <= at_end;
        end
    end
endmodule

// ### verilog/alarm_response.sv
/*
 Alarm response and parameter gate of a motor protection controller,
 with its AXI4-Lite register slave and a level interrupt.
 Assumes alarm inputs and bus commands synchronous to aclk.
*/
`timescale 1ns/1ps
module alarm_response #(
    parameter int unsigned     N       = alarm_pkg::NUM_ALARMS,
    parameter longint unsigned HOUR_CY = alarm_pkg::RECOVER_CYCLES
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [31:0]   s_axil_awaddr,
    input  wire logic          s_axil_awvalid,
    output logic               s_axil_awready,
    input  wire logic [31:0]   s_axil_wdata,
    input  wire logic [3:0]    s_axil_wstrb,
    input  wire logic          s_axil_wvalid,
    output logic               s_axil_wready,
    output logic [1:0]         s_axil_bresp,
    output logic               s_axil_bvalid,
    input  wire logic          s_axil_bready,
    input  wire logic [31:0]   s_axil_araddr,
    input  wire logic          s_axil_arvalid,
    output logic               s_axil_arready,
    output logic [31:0]        s_axil_rdata,
    output logic [1:0]         s_axil_rresp,
    output logic               s_axil_rvalid,
    input  wire logic          s_axil_rready,
    input  wire logic [N-1:0]  alarm_in,
    input  wire logic          motor_running,
    input  wire logic          start_phase,
    input  wire logic          drawer_test_or_oper,
    input  wire logic          mode_remote_or_local,
    input  wire logic          coil_write,
    input  wire logic [7:0]    coil_addr,
    input  wire logic          fieldbus_reset_telegram,
    input  wire logic          param_wr_req,
    input  wire logic          param_wr_fieldbus,
    output logic               contactor_trip,
    output logic               warning_out,
    output logic               param_accept,
    output logic               irq
);
    logic [N-1:0]  enable_q, warncls_q, manual_q, latch_q;
    logic [10:0]   func_q;
    logic [1:0]    ar_left_q;
    logic [2:0]    irq_stat_q, irq_mask_q;
    logic          aw_q, w_q;
    logic [7:0]    awaddr_q;
    logic [31:0]   wdata_q;
    logic          sw_reset_q;

    function automatic logic [15:0] w16(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
        w16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Start phase masking
    wire [N-1:0] start_ign;
    assign start_ign = (N'(func_q[alarm_pkg::F_IGN_PL]) << alarm_pkg::A_PHASELOSS)
                     | (N'(func_q[alarm_pkg::F_IGN_EF]) << alarm_pkg::A_EARTH)
                     | (N'(func_q[alarm_pkg::F_IGN_UB]) << alarm_pkg::A_UNBAL)
                     | (N'(func_q[alarm_pkg::F_IGN_UC]) << alarm_pkg::A_UNDERCUR)
                     | (N'(func_q[alarm_pkg::F_IGN_OC]) << alarm_pkg::A_OVERCUR);
    wire [N-1:0] live = alarm_in & enable_q & ~(start_phase ? start_ign : '0);

    // Reset commands
    wire coil_hit = coil_write && coil_addr >= alarm_pkg::COIL_FIRST
                    && coil_addr <= alarm_pkg::COIL_LAST;
    wire reset_cmd = coil_hit || fieldbus_reset_telegram || sw_reset_q;

    // Overload auto reset
    wire [2:0] ar_sel   = func_q[alarm_pkg::F_AR_LSB +: 3];
    wire       ol_bit   = latch_q[alarm_pkg::A_OVERLOAD];
    wire       ol_live  = live[alarm_pkg::A_OVERLOAD];
    wire       ar_ok    = (ar_sel == alarm_pkg::AR_ALWAYS) || (ar_left_q != 2'h0);
    wire       auto_rst = ol_bit && !ol_live && !manual_q[alarm_pkg::A_OVERLOAD] && ar_ok;
    wire       hour_done;

    hour_timer #(.LIMIT(HOUR_CY)) hour_timer_i (
        .aclk    (aclk),
        .aresetn (aresetn),
        .restart (ol_live),
        .expired (hour_done)
    );

    // Latch: manual alarms, and the overload once its allowance is spent, hold until a reset; others follow the condition
    wire [N-1:0] clr_ok = ~manual_q | (reset_cmd ? '1 : '0);
    wire [N-1:0] ol_hold = N'(!ar_ok) << alarm_pkg::A_OVERLOAD;
    wire [N-1:0] ol_auto = N'(auto_rst) << alarm_pkg::A_OVERLOAD;
    wire [N-1:0] latch_d = live | (latch_q & ~(clr_ok & ~(ol_hold & ~(reset_cmd ? '1 : '0))))
                         & ~(ol_auto & ~live);
    wire       fault_any = |(latch_q & ~warncls_q);
    wire       warn_any  = |(latch_q & warncls_q);

    // Parameter acceptance
    wire ma = func_q[alarm_pkg::F_MODE_A];
    wire mb = func_q[alarm_pkg::F_MODE_B];
    wire accept_now = (!ma && !mb) ? !motor_running
                    : ( ma && !mb) ? param_wr_fieldbus
                    : (!ma &&  mb) ? (param_wr_fieldbus && !drawer_test_or_oper)
                    :                (param_wr_fieldbus && !mode_remote_or_local);
    wire rejected = param_wr_req && !accept_now;

    // Bus decode
    wire wr_go = aw_q && w_q && !s_axil_bvalid;
    wire rd_go = s_axil_arvalid && s_axil_arready;
    wire [7:0] ra = s_axil_araddr[7:0];
    wire rd_stat = rd_go && ra == alarm_pkg::OFF_IRQ_STAT;
    wire [2:0] ev = {rejected, warn_any, fault_any};
    wire [31:0] rmux =
          (ra == alarm_pkg::OFF_ENABLE)   ? 32'(enable_q)
        : (ra == alarm_pkg::OFF_WARNCLS)  ? 32'(warncls_q)
        : (ra == alarm_pkg::OFF_MANUAL)   ? 32'(manual_q)
        : (ra == alarm_pkg::OFF_FUNC)     ? 32'(func_q)
        : (ra == alarm_pkg::OFF_ACTIVE)   ? 32'(latch_q)
        : (ra == alarm_pkg::OFF_STATUS)   ? {26'h0, ar_left_q, param_accept, warn_any,
                                             fault_any, contactor_trip}
        : (ra == alarm_pkg::OFF_IRQ_STAT) ? 32'(irq_stat_q)
        : (ra == alarm_pkg::OFF_IRQ_MASK) ? 32'(irq_mask_q)
        : (ra == alarm_pkg::OFF_DEBUG)    ? (func_q[alarm_pkg::F_DEBUG] ?
                                             {latch_q, live} : 32'h0)
        : 32'h0;
    wire rd_ok = ra <= alarm_pkg::OFF_DEBUG && ra[1:0] == 2'h0;
    wire wr_ok = awaddr_q <= alarm_pkg::OFF_DEBUG && awaddr_q[1:0] == 2'h0
                 && awaddr_q != alarm_pkg::OFF_ACTIVE && awaddr_q != alarm_pkg::OFF_STATUS
                 && awaddr_q != alarm_pkg::OFF_IRQ_STAT && awaddr_q != alarm_pkg::OFF_DEBUG;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q           <= 1'b0;
            w_q            <= 1'b0;
            awaddr_q       <= 8'h0;
            wdata_q        <= 32'h0;
            s_axil_awready <= 1'b0;
            s_axil_wready  <= 1'b0;
            s_axil_bvalid  <= 1'b0;
            s_axil_bresp   <= 2'h0;
            s_axil_arready <= 1'b0;
            s_axil_rvalid  <= 1'b0;
            s_axil_rdata   <= 32'h0;
            s_axil_rresp   <= 2'h0;
        end else begin
            s_axil_awready <= !aw_q && !s_axil_awready && s_axil_awvalid;
            s_axil_wready  <= !w_q && !s_axil_wready && s_axil_wvalid;
            if (s_axil_awvalid && s_axil_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axil_awaddr[7:0];
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axil_wdata;
            end
            if (wr_go) begin
                aw_q          <= 1'b0;
                w_q           <= 1'b0;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
            s_axil_arready <= !s_axil_arready && !s_axil_rvalid && s_axil_arvalid;
            if (rd_go) begin
                s_axil_rvalid <= 1'b1;
                s_axil_rdata  <= rd_ok ? rmux : 32'h0;
                s_axil_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axil_rready) begin
                s_axil_rvalid <= 1'b0;
            end
        end
    end

    wire [3:0] st = s_axil_wstrb;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q   <= N'(alarm_pkg::RST_ENABLE);
            warncls_q  <= N'(alarm_pkg::RST_WARNCLS);
            manual_q   <= N'(alarm_pkg::RST_MANUAL);
            func_q     <= alarm_pkg::RST_FUNC;
            irq_mask_q <= 3'h0;
            sw_reset_q <= 1'b0;
        end else begin
            sw_reset_q <= wr_go && awaddr_q == alarm_pkg::OFF_RESET && wdata_q[0];
            if (wr_go && awaddr_q == alarm_pkg::OFF_ENABLE)
                enable_q <= N'(w16(32'(enable_q), wdata_q, st));
            if (wr_go && awaddr_q == alarm_pkg::OFF_WARNCLS)
                warncls_q <= N'(w16(32'(warncls_q), wdata_q, st));
            if (wr_go && awaddr_q == alarm_pkg::OFF_MANUAL)
                manual_q <= N'(w16(32'(manual_q), wdata_q, st));
            if (wr_go && awaddr_q == alarm_pkg::OFF_FUNC)
                func_q <= 11'(w16(32'(func_q), wdata_q, st));
            if (wr_go && awaddr_q == alarm_pkg::OFF_IRQ_MASK && st[0])
                irq_mask_q <= wdata_q[2:0];
        end
    end

    // Allowance reload on one hour clear, or a reset command with no live overload; one less per auto reset except under code 4
    wire [1:0] ar_cfg = (ar_sel > 3'h3) ? 2'h3 : ar_sel[1:0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q        <= '0;
            ar_left_q      <= alarm_pkg::RST_FUNC[alarm_pkg::F_AR_LSB +: 2];
            irq_stat_q     <= 3'h0;
            contactor_trip <= 1'b0;
            warning_out    <= 1'b0;
            param_accept   <= 1'b0;
            irq            <= 1'b0;
        end else begin
            latch_q <= latch_d;
            if (hour_done || (reset_cmd && !ol_live))
                ar_left_q <= ar_cfg;
            else if (auto_rst && ar_sel != alarm_pkg::AR_ALWAYS)
                ar_left_q <= ar_left_q - 2'h1;
            // Set wins over the read clear
            irq_stat_q     <= (rd_stat ? 3'h0 : irq_stat_q) | ev;
            contactor_trip <= fault_any;
            warning_out    <= warn_any;
            param_accept   <= param_wr_req && accept_now;
            irq            <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Contactor and warning outputs trail the latch by one cycle
    trip_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_any |=> contactor_trip)
        else $error("fault did not open contactor");

    warn_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (latch_q != '0 && (latch_q & ~warncls_q) == '0) |=> !contactor_trip)
        else $error("warning opened contactor");

    warn_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        warn_any |=> warning_out)
        else $error("warning not shown");

    disabled_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ($stable(enable_q) && latch_q == '0 && (alarm_in & enable_q) == '0)
        |=> latch_q == '0)
        else $error("disabled alarm latched");

    start_ign_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (start_phase && latch_q == '0 && (alarm_in & enable_q & ~start_ign) == '0)
        |=> latch_q == '0)
        else $error("suppressed alarm latched in start phase");

    manual_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(latch_q & manual_q) && !reset_cmd && $stable(manual_q))
        |=> |(latch_q & $past(manual_q)))
        else $error("manual alarm lost");

    coil_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (coil_write && coil_addr == 8'h40 && !fieldbus_reset_telegram && !sw_reset_q)
        |-> !reset_cmd)
        else $error("coil 64 reset");

    // A reset command leaves only what is still live
    coil_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (coil_write && coil_addr == alarm_pkg::COIL_LAST) |=> latch_q == $past(live))
        else $error("last reset coil ignored");

    stopped_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (param_wr_req && !ma && !mb && motor_running) |=> !param_accept)
        else $error("param accepted while running");

    mode_a_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (param_wr_req && ma && !mb && param_wr_fieldbus) |=> param_accept)
        else $error("fieldbus param refused");

    drawer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (param_wr_req && !ma && mb && drawer_test_or_oper) |=> !param_accept)
        else $error("param in test position");

    remote_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (param_wr_req && ma && mb && mode_remote_or_local) |=> !param_accept)
        else $error("param in remote or local");

    debug_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_go && ra == alarm_pkg::OFF_DEBUG && !func_q[alarm_pkg::F_DEBUG])
        |=> s_axil_rdata == 32'h0)
        else $error("debug view shown while off");

    hour_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hour_done |=> ar_left_q == $past(ar_cfg))
        else $error("allowance not restored");

    ar_dec_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (auto_rst && ar_sel != alarm_pkg::AR_ALWAYS && !hour_done && !reset_cmd)
        |=> ar_left_q == $past(ar_left_q) - 2'h1)
        else $error("allowance not spent");

    // With the allowance spent only a reset command may clear the overload
    ar_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ol_bit && !ar_ok && !reset_cmd) |=> latch_q[alarm_pkg::A_OVERLOAD])
        else $error("overload cleared with no allowance");
endmodule

// ### sim/fieldbus_master_model.sv
/*
 Model of the fieldbus master and Modbus client: reset coils, reset telegrams
 and parameter write requests, called as tasks by the bench.
 Assumes one aclk domain; all lines change just after a rising edge.
*/
`timescale 1ns/1ps
module fieldbus_master_model (
    input  wire logic  aclk,
    input  wire logic  param_accept,
    output logic       coil_write,
    output logic [7:0] coil_addr,
    output logic       fieldbus_reset_telegram,
    output logic       param_wr_req,
    output logic       param_wr_fieldbus
);
    initial begin
        coil_write = 1'b0;
        coil_addr = 8'h00;
        fieldbus_reset_telegram = 1'b0;
        param_wr_req = 1'b0;
        param_wr_fieldbus = 1'b0;
    end

    // Single coil write; the address is scrambled after, it means nothing then
    task automatic coil(input logic [7:0] a);
        @(posedge aclk);
        coil_write <= 1'b1;
        coil_addr <= a;
        @(posedge aclk);
        coil_write <= 1'b0;
        coil_addr <= ~a;
    endtask

    task automatic telegram();
        @(posedge aclk);
        fieldbus_reset_telegram <= 1'b1;
        @(posedge aclk);
        fieldbus_reset_telegram <= 1'b0;
    endtask

    // Accept is a one cycle pulse, so it is read just after the next edge
    task automatic param(input logic fb, output logic acc);
        @(posedge aclk);
        param_wr_req <= 1'b1;
        param_wr_fieldbus <= fb;
        @(posedge aclk);
        param_wr_req <= 1'b0;
        param_wr_fieldbus <= ~fb;
        #1 acc = param_accept;
    endtask
endmodule

// ### sim/alarm_response_tb.sv
/*
 Self-checking bench of the alarm response block: AXI4-Lite tasks, alarm
 stimulus and the fieldbus model. Assumes the hour interval shortened to 50.
*/
`timescale 1ns/1ps
module alarm_response_tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] s_axil_awaddr = '0, s_axil_wdata = '0, s_axil_araddr = '0, s_axil_rdata;
    logic [3:0]  s_axil_wstrb = '0;
    logic        s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
    logic        s_axil_arvalid = 0, s_axil_rready = 0;
    logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0]  s_axil_bresp, s_axil_rresp;
    logic [15:0] alarm_in = '0;
    logic        motor_running = 0, start_phase = 0, drawer_test_or_oper = 0;
    logic        mode_remote_or_local = 0, coil_write, fieldbus_reset_telegram;
    logic [7:0]  coil_addr;
    logic        param_wr_req, param_wr_fieldbus, contactor_trip, warning_out, param_accept, irq;
    logic        acc;
    int          miscompares = 0, tests_run = 0;
    int          fb[5] = '{0, 1, 4, 5, 6};
    int          ai[5] = '{11, 12, 1, 2, 3};
    logic [7:0]  ca[4] = '{8'h40, 8'h41, 8'h6b, 8'h6a};

    alarm_response #(.HOUR_CY(50)) alarm_response_i (.aclk(aclk), .aresetn(aresetn),
        .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .alarm_in(alarm_in),
        .motor_running(motor_running), .start_phase(start_phase),
        .drawer_test_or_oper(drawer_test_or_oper), .mode_remote_or_local(mode_remote_or_local),
        .coil_write(coil_write), .coil_addr(coil_addr),
        .fieldbus_reset_telegram(fieldbus_reset_telegram), .param_wr_req(param_wr_req),
        .param_wr_fieldbus(param_wr_fieldbus), .contactor_trip(contactor_trip),
        .warning_out(warning_out), .param_accept(param_accept), .irq(irq));

    fieldbus_master_model fieldbus_master_model_i (.aclk(aclk), .param_accept(param_accept),
        .coil_write(coil_write), .coil_addr(coil_addr),
        .fieldbus_reset_telegram(fieldbus_reset_telegram), .param_wr_req(param_wr_req),
        .param_wr_fieldbus(param_wr_fieldbus));

    initial begin
        forever #50 aclk = ~aclk;
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Both channels offered together, each dropped when its ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge aclk);
        s_axil_awaddr <= {24'h0, a};
        s_axil_wdata <= d;
        s_axil_wstrb <= 4'hf;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
            if (s_axil_bvalid) break;
        end
        if (i == 40) begin
            miscompares++;
            give_verdict();
        end
        chk({30'h0, s_axil_bresp}, {30'h0, er});
        s_axil_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int i;
        @(posedge aclk);
        s_axil_araddr <= {24'h0, a};
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
            if (s_axil_rvalid) break;
        end
        if (i == 40) begin
            miscompares++;
            give_verdict();
        end
        chk(s_axil_rdata, ed);
        chk({30'h0, s_axil_rresp}, {30'h0, er});
        s_axil_rready <= 1'b0;
    endtask

    // Alarm levels and start phase, then time for latch and output to follow
    task automatic al(input logic [15:0] v, input logic sp);
        @(posedge aclk);
        alarm_in <= v;
        start_phase <= sp;
        cyc(5);
    endtask

    function automatic logic exp_acc(input int m, input int j);
        case (m)
            0: return !j[1];
            1: return j[0];
            2: return j[0] && !j[2];
            default: return j[0] && !j[3];
        endcase
    endfunction

    initial begin
        cyc(12);
        aresetn <= 1'b1;
        rd(alarm_pkg::OFF_ENABLE, 32'hffff, 2'h0);
        rd(alarm_pkg::OFF_FUNC, 32'h100, 2'h0);
        rd(alarm_pkg::OFF_MANUAL, 32'h0, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(alarm_pkg::OFF_ACTIVE, 32'h1, 2'h2);
        wr(alarm_pkg::OFF_MANUAL, 32'h20, 2'h0);
        wr(alarm_pkg::OFF_IRQ_MASK, 32'h1, 2'h0);
        for (int i = 0; i < 4; i++) begin
            al(16'h0020, 1'b0);
            chk(contactor_trip, 1'b1);
            chk(irq, 1'b1);
            al(16'h0000, 1'b0);
            fieldbus_master_model_i.coil(ca[i]);
            cyc(4);
            // Only coils inside the reset range clear the held alarm
            chk(contactor_trip, ca[i] < alarm_pkg::COIL_FIRST
                || ca[i] > alarm_pkg::COIL_LAST);
        end
        rd(alarm_pkg::OFF_IRQ_STAT, 32'h1, 2'h0);
        cyc(3);
        chk(irq, 1'b0);
        wr(alarm_pkg::OFF_FUNC, 32'h180, 2'h0);
        al(16'h0020, 1'b0);
        rd(alarm_pkg::OFF_DEBUG, 32'h00200020, 2'h0);
        wr(alarm_pkg::OFF_FUNC, 32'h100, 2'h0);
        rd(alarm_pkg::OFF_DEBUG, 32'h0, 2'h0);
        wr(alarm_pkg::OFF_WARNCLS, 32'h20, 2'h0);
        al(16'h0000, 1'b0);
        fieldbus_master_model_i.telegram();
        al(16'h0020, 1'b0);
        al(16'h0000, 1'b0);
        chk({contactor_trip, warning_out}, 2'b01);
        wr(alarm_pkg::OFF_RESET, 32'h1, 2'h0);
        cyc(4);
        chk(warning_out, 1'b0);
        wr(alarm_pkg::OFF_WARNCLS, 32'h0, 2'h0);
        wr(alarm_pkg::OFF_ENABLE, 32'hffdf, 2'h0);
        al(16'h0020, 1'b0);
        chk(contactor_trip, 1'b0);
        al(16'h0000, 1'b0);
        wr(alarm_pkg::OFF_ENABLE, 32'hffff, 2'h0);
        // Feedback supervision alarm; its contact or current source counts as configured
        al(16'h0400, 1'b0);
        chk(contactor_trip, 1'b1);
        al(16'h0000, 1'b0);
        for (int i = 0; i < 5; i++) begin
            wr(alarm_pkg::OFF_FUNC, 32'h100 | (32'h1 << fb[i]), 2'h0);
            al(16'h1 << ai[i], 1'b1);
            chk(contactor_trip, 1'b0);
            al(16'h1 << ai[i], 1'b0);
            chk(contactor_trip, 1'b1);
            al(16'h0000, 1'b0);
        end
        // Codes 0..3 are the only ones an explosive area setup may use; 4 is unlimited
        for (int c = 0; c < 5; c++) begin
            wr(alarm_pkg::OFF_FUNC, {21'h0, c[2:0], 8'h00}, 2'h0);
            fieldbus_master_model_i.telegram();
            cyc(3);
            for (int k = 0; k < 4; k++) begin
                al(16'h0001, 1'b0);
                al(16'h0000, 1'b0);
                chk(contactor_trip, c != 4 && k >= c);
            end
        end
        wr(alarm_pkg::OFF_FUNC, 32'h100, 2'h0);
        fieldbus_master_model_i.telegram();
        al(16'h0001, 1'b0);
        al(16'h0000, 1'b0);
        cyc(70);
        al(16'h0001, 1'b0);
        al(16'h0000, 1'b0);
        chk(contactor_trip, 1'b0);
        for (int m = 0; m < 4; m++) begin
            wr(alarm_pkg::OFF_FUNC, {21'h0, 3'h1, 4'h0, m[1:0], 2'h0}, 2'h0);
            for (int j = 0; j < 16; j++) begin
                @(posedge aclk);
                motor_running <= j[1];
                drawer_test_or_oper <= j[2];
                mode_remote_or_local <= j[3];
                fieldbus_master_model_i.param(j[0], acc);
                chk(acc, exp_acc(m, j));
            end
        end
        give_verdict();
    end
endmodule
